/* qbp_port_pins.sv */
// Notes on behaviour
// - After and during reset every pin is general I/O in input mode until software picks a function.
// - Each of the 24 pins takes its own function code, independent of all others.
// - The pin mode follows the function: quasi for I/O and serial, open drain for two-wire, analog, push-pull, input-only.
// - One latch register per port is written whole or one bit at a time.
// - A zero in the latch turns the low driver on and the high driver and pull-ups off.
// - A one releases the low driver, drives high for exactly one clock and enables the weak pull-ups.
// - The high pulse comes only on a zero-to-one change of the driving value, never on a repeated one.
// - After the pulse the weak pull-up stays on while the value is one, the strong one only while the pin also reads high.
// - The external address/data bus is never used as general I/O and is not handled here.
// - Reset sets every latch bit of all three ports to one.
// - Read-modify-write reads return the latch, all other reads return the sampled pin; a read of the unused port index returns zero.
// - When a resting-high pin is pulled low from outside, the stronger pull-up switches off.
module qbp_port_pins (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input qbp_pkg::qbp_write_s wrReq,
  input wire logic [1:0] rdPort,
  input wire logic rdModifyWrite,
  input wire logic [qbp_pkg::QBP_PORTS*3*qbp_pkg::QBP_WIDTH-1:0] pinFunc,
  input wire logic [qbp_pkg::QBP_PORTS*qbp_pkg::QBP_WIDTH-1:0] altOut,
  input wire logic [qbp_pkg::QBP_PORTS*qbp_pkg::QBP_WIDTH-1:0] pinIn,
  output logic [7:0] readData,
  output logic [qbp_pkg::QBP_PORTS*qbp_pkg::QBP_WIDTH-1:0] lowDrive,
  output logic [qbp_pkg::QBP_PORTS*qbp_pkg::QBP_WIDTH-1:0] highDrive,
  output logic [qbp_pkg::QBP_PORTS*qbp_pkg::QBP_WIDTH-1:0] strongPull,
  output logic [qbp_pkg::QBP_PORTS*qbp_pkg::QBP_WIDTH-1:0] weakPull
);
  import qbp_pkg::*;

  localparam int NPIN = QBP_PORTS * QBP_WIDTH;

  qbp_state_s st;
  qbp_state_s next_st;
  qbp_mode_e pinMode [NPIN];
  qbp_drive_s pinDrv [NPIN];
  logic [NPIN-1:0] srcBit;

  // Each pin decodes its own function code, so no pin limits another.
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    logic [2:0] fn;
    logic src;
    logic dly;
    assign fn = pinFunc[3*i +: 3];
    always_comb begin
      case (qbp_func_e'(fn))
        QBP_FN_GPIO, QBP_FN_SERIAL: pinMode[i] = QBP_MODE_QUASI;
        QBP_FN_TWOWIRE: pinMode[i] = QBP_MODE_DRAIN;
        QBP_FN_ANALOG: pinMode[i] = QBP_MODE_ANALOG;
        QBP_FN_CNT_OUT: pinMode[i] = QBP_MODE_PUSH;
        QBP_FN_CNT_IN: pinMode[i] = QBP_MODE_INPUT;
        default: pinMode[i] = QBP_MODE_QUASI;
      endcase
    end
    // General I/O drives from the latch, serial and push-pull from the peripheral.
    assign srcBit[i] = (qbp_func_e'(fn) == QBP_FN_GPIO) ? st.latch[i/8][i%8] : altOut[i];
    assign src = st.drvSrc[i/8][i%8];
    assign dly = st.drvDly[i/8][i%8];
    always_comb begin
      pinDrv[i] = '0;
      case (pinMode[i])
        QBP_MODE_QUASI: begin
          pinDrv[i].lowDrive = !src;
          pinDrv[i].highDrive = src && !dly;
          pinDrv[i].weakPull = src;
          // The strong pull-up drops once the outside pulls a resting pin low.
          // The pin sample lags the drive by two edges, so right after the pulse a low sample is our own.
          pinDrv[i].strongPull = src && !(dly && !st.highDrive[i] && !st.pinSeen[i/8][i%8]);
        end
        QBP_MODE_DRAIN: begin
          pinDrv[i].lowDrive = !src;
          pinDrv[i].weakPull = src;
        end
        QBP_MODE_PUSH: begin
          pinDrv[i].lowDrive = !src;
          pinDrv[i].highDrive = src;
        end
        QBP_MODE_INPUT: begin
          // Input-only pins rest high on the pull-ups.
          pinDrv[i].weakPull = 1'b1;
          pinDrv[i].strongPull = st.pinSeen[i/8][i%8];
        end
        QBP_MODE_ANALOG: pinDrv[i] = '0;
        default: pinDrv[i] = '0;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    if (wrReq.wrEn && wrReq.port <= QBP_IDX_FOUR) begin
      if (wrReq.bitMode) begin
        next_st.latch[wrReq.port][wrReq.bitSel] = wrReq.data[0];
      end else begin
        next_st.latch[wrReq.port] = wrReq.data;
      end
    end
    next_st.drvSrc = srcBit;
    next_st.drvDly = st.drvSrc;
    next_st.pinSeen = pinIn;
    for (int i = 0; i < NPIN; i++) begin
      next_st.lowDrive[i] = pinDrv[i].lowDrive;
      next_st.highDrive[i] = pinDrv[i].highDrive;
      next_st.strongPull[i] = pinDrv[i].strongPull;
      next_st.weakPull[i] = pinDrv[i].weakPull;
    end
    if (rdPort > QBP_IDX_FOUR) begin
      next_st.readData = 8'h00;
    end else if (rdModifyWrite) begin
      next_st.readData = st.latch[rdPort];
    end else begin
      next_st.readData = st.pinSeen[rdPort];
    end
  end

  // Reset state equals idle input mode: latch at one, pins resting on the pull-ups.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st.latch <= {QBP_PORTS{QBP_LATCH_RESET}};
      st.drvSrc <= '1;
      st.drvDly <= '1;
      st.pinSeen <= '1;
      st.lowDrive <= '0;
      st.highDrive <= '0;
      st.strongPull <= '1;
      st.weakPull <= '1;
      st.readData <= 8'h00;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // The external bus pins never pass through this block.
  assign readData = st.readData;
  assign lowDrive = st.lowDrive;
  assign highDrive = st.highDrive;
  assign strongPull = st.strongPull;
  assign weakPull = st.weakPull;

  property p_pulse_one_cycle;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && highDrive[0] && pinMode[0] == QBP_MODE_QUASI ##1 clkEn |-> !highDrive[0];
  endproperty
  a_pulse_one_cycle: assert property (p_pulse_one_cycle) else $error("high pulse longer than one cycle");

  property p_pulse_on_rise;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && pinMode[0] == QBP_MODE_QUASI && st.drvSrc[0][0] && !st.drvDly[0][0] |=> highDrive[0] || !clkEn;
  endproperty
  a_pulse_on_rise: assert property (p_pulse_on_rise) else $error("no high pulse on rising value");

  property p_no_pulse_held;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && pinMode[0] == QBP_MODE_QUASI && st.drvDly[0][0] |=> !highDrive[0] || !clkEn;
  endproperty
  a_no_pulse_held: assert property (p_no_pulse_held) else $error("high pulse on repeated one");

  property p_low_exclusive;
    @(posedge sys_clk) disable iff (!resetn) lowDrive[5] |-> !highDrive[5] && !weakPull[5] && !strongPull[5];
  endproperty
  a_low_exclusive: assert property (p_low_exclusive) else $error("low driver with pull-up");

  property p_quasi_pull;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && pinMode[3] == QBP_MODE_QUASI && st.drvSrc[0][3] |=> weakPull[3] || !clkEn;
  endproperty
  a_quasi_pull: assert property (p_quasi_pull) else $error("weak pull-up missing while high");

  property p_write_full;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && wrReq.wrEn && !wrReq.bitMode && wrReq.port == QBP_IDX_THREE |=> st.latch[1] == $past(wrReq.data);
  endproperty
  a_write_full: assert property (p_write_full) else $error("port latch write lost");

  property p_rmw_read;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && rdModifyWrite && rdPort == QBP_IDX_ONE |=> readData == $past(st.latch[0]);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("modify read not from latch");

  property p_pin_read;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && !rdModifyWrite && rdPort == QBP_IDX_FOUR |=> readData == $past(st.pinSeen[2]);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("plain read not from pin");

  property p_strong_off;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && pinMode[7] == QBP_MODE_QUASI && st.drvSrc[0][7] && st.drvDly[0][7] && !highDrive[7]
        && !st.pinSeen[0][7] |=> !strongPull[7] || !clkEn;
  endproperty
  a_strong_off: assert property (p_strong_off) else $error("strong pull-up kept against low pin");

  property p_low_follow;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && pinMode[0] == QBP_MODE_QUASI && !st.drvSrc[0][0] |=> lowDrive[0];
  endproperty
  a_low_follow: assert property (p_low_follow) else $error("low driver missing for a zero");

  property p_analog_off;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && pinMode[0] == QBP_MODE_ANALOG |=> !lowDrive[0] && !highDrive[0] && !strongPull[0] && !weakPull[0];
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog pin still driven");

  property p_drain_no_pulse;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && pinMode[1] == QBP_MODE_DRAIN |=> !highDrive[1] && !strongPull[1];
  endproperty
  a_drain_no_pulse: assert property (p_drain_no_pulse) else $error("open drain pin driven high");

  property p_push_drive;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && pinMode[4] == QBP_MODE_PUSH |=> highDrive[4] != lowDrive[4] && !strongPull[4] && !weakPull[4];
  endproperty
  a_push_drive: assert property (p_push_drive) else $error("push-pull pin not driven one way");

  // Input-only pins must never drive, whatever the peripheral output holds.
  property p_input_only;
    @(posedge sys_clk) disable iff (!resetn)
      clkEn && pinMode[6] == QBP_MODE_INPUT |=> weakPull[6] && !lowDrive[6] && !highDrive[6];
  endproperty
  a_input_only: assert property (p_input_only) else $error("input-only pin driven");
endmodule

/* qbp_pkg.sv */
package qbp_pkg;
  localparam int QBP_PORTS = 3;
  localparam int QBP_WIDTH = 8;
  localparam logic [7:0] QBP_LATCH_RESET = 8'hff;
  localparam logic [2:0] QBP_FUNC_RESET = 3'h0;
  localparam logic [1:0] QBP_IDX_ONE = 2'h0;
  localparam logic [1:0] QBP_IDX_THREE = 2'h1;
  localparam logic [1:0] QBP_IDX_FOUR = 2'h2;

  // Function code per pin; the pin mode follows from it.
  typedef enum logic [2:0] {
    QBP_FN_GPIO = 3'h0,
    QBP_FN_SERIAL = 3'h1,
    QBP_FN_TWOWIRE = 3'h2,
    QBP_FN_ANALOG = 3'h3,
    QBP_FN_CNT_OUT = 3'h4,
    QBP_FN_CNT_IN = 3'h5
  } qbp_func_e;

  typedef enum logic [4:0] {
    QBP_MODE_QUASI = 5'h01,
    QBP_MODE_DRAIN = 5'h02,
    QBP_MODE_ANALOG = 5'h04,
    QBP_MODE_PUSH = 5'h08,
    QBP_MODE_INPUT = 5'h10
  } qbp_mode_e;

  typedef struct packed {
    logic lowDrive;
    logic highDrive;
    logic strongPull;
    logic weakPull;
  } qbp_drive_s;

  typedef struct packed {
    logic wrEn;
    logic [1:0] port;
    logic bitMode;
    logic [2:0] bitSel;
    logic [7:0] data;
  } qbp_write_s;

  typedef struct packed {
    logic [QBP_PORTS-1:0][QBP_WIDTH-1:0] latch;
    logic [QBP_PORTS-1:0][QBP_WIDTH-1:0] drvSrc;
    logic [QBP_PORTS-1:0][QBP_WIDTH-1:0] drvDly;
    logic [QBP_PORTS-1:0][QBP_WIDTH-1:0] pinSeen;
    logic [QBP_PORTS*QBP_WIDTH-1:0] lowDrive;
    logic [QBP_PORTS*QBP_WIDTH-1:0] highDrive;
    logic [QBP_PORTS*QBP_WIDTH-1:0] strongPull;
    logic [QBP_PORTS*QBP_WIDTH-1:0] weakPull;
    logic [7:0] readData;
  } qbp_state_s;
endpackage

/* qbp_ext_dev.sv */
// An external sink always wins over the pin's own pull-ups.
// A pin with no driver and no sink floats high through the board pull-up.
module qbp_ext_dev (
  input wire logic [23:0] lowDrive,
  input wire logic [23:0] extLow,
  output logic [23:0] pinIn
);
  always_comb pinIn = ~(lowDrive | extLow);
endmodule

/* tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import qbp_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, rdModifyWrite = 1'b0;
  qbp_write_s wrReq = '0;
  logic [1:0] rdPort = 2'h0;
  logic [71:0] pinFunc = '0;
  logic [23:0] altOut = '0, extLow = '0, pinIn, lowDrive, highDrive, strongPull, weakPull;
  logic [7:0] readData;
  int n_fail = 0, total_checks = 0, pulses1, pulses2;
  always #25 sys_clk = ~sys_clk;
  qbp_port_pins qbp_port_pins_i (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .wrReq(wrReq),
    .rdPort(rdPort), .rdModifyWrite(rdModifyWrite), .pinFunc(pinFunc), .altOut(altOut), .pinIn(pinIn),
    .readData(readData), .lowDrive(lowDrive), .highDrive(highDrive), .strongPull(strongPull),
    .weakPull(weakPull));
  qbp_ext_dev qbp_ext_dev_i (.lowDrive(lowDrive), .extLow(extLow), .pinIn(pinIn));
  task end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [95:0] got, input logic [95:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task wr(input logic [1:0] p, input logic bm, input logic [2:0] s, input logic [7:0] d);
    @(posedge sys_clk);
    wrReq <= '{1'b1, p, bm, s, d};
    @(posedge sys_clk);
    wrReq.wrEn <= 1'b0;
    tick(2);
  endtask
  task rd(input logic [1:0] p, input logic rmw, input logic [7:0] exp);
    @(posedge sys_clk);
    rdPort <= p;
    rdModifyWrite <= rmw;
    tick(1);
    chk(readData, exp);
  endtask
  task t_reset;
    tick(10);
    chk({lowDrive, highDrive, strongPull, weakPull}, {48'h0, {48{1'b1}}});
    tick(9);
    @(posedge sys_clk);
    resetn <= 1'b1;
    tick(3);
    chk({lowDrive, highDrive, strongPull, weakPull}, {48'h0, {48{1'b1}}});
    rd(2'h0, 1'b1, 8'hff);
    rd(2'h2, 1'b1, 8'hff);
    rd(2'h3, 1'b1, 8'h00);
  endtask
  task t_low_high;
    wr(2'h0, 1'b0, 3'h0, 8'h00);
    chk({lowDrive, highDrive, strongPull, weakPull}, {24'hff, 24'h0, {2{24'hffff00}}});
    rd(2'h0, 1'b0, 8'h00);
    wr(2'h0, 1'b0, 3'h0, 8'hff);
    chk({lowDrive, highDrive, strongPull, weakPull}, {24'h0, 24'hff, {48{1'b1}}});
    tick(1);
    chk({lowDrive, highDrive, strongPull, weakPull}, {48'h0, {48{1'b1}}});
    wr(2'h0, 1'b0, 3'h0, 8'hff);
    chk(highDrive, 24'h0);
  endtask
  task t_bit_ext;
    wr(2'h2, 1'b1, 3'h3, 8'h00);
    chk({lowDrive, strongPull, weakPull}, {24'h080000, {2{24'hf7ffff}}});
    rd(2'h2, 1'b1, 8'hf7);
    @(posedge sys_clk);
    extLow <= 24'h000100;
    tick(3);
    chk({strongPull, weakPull}, {24'hf7feff, 24'hf7ffff});
    rd(2'h1, 1'b0, 8'hfe);
    rd(2'h1, 1'b1, 8'hff);
    @(posedge sys_clk);
    extLow <= 24'h0;
  endtask
  // Pulse counts, not exact cycles, judge the routed pins, since their latency is unstated.
  task t_modes;
    @(posedge sys_clk);
    pinFunc[8:0] <= {QBP_FN_SERIAL, QBP_FN_TWOWIRE, QBP_FN_ANALOG};
    tick(4);
    chk({lowDrive[0], highDrive[0], strongPull[0], weakPull[0]}, 4'h0);
    pulses1 = 0;
    pulses2 = 0;
    @(posedge sys_clk);
    altOut[2:1] <= 2'b11;
    repeat (6) begin
      tick(1);
      pulses1 += highDrive[1];
      pulses2 += highDrive[2];
    end
    chk({lowDrive[2:1], weakPull[1]}, 3'h1);
    chk({pulses1[7:0], pulses2[7:0]}, 16'h0001);
  endtask
  task t_wide;
    wr(2'h1, 1'b0, 3'h0, 8'h5a);
    chk(lowDrive[15:8], 8'ha5);
    rd(2'h1, 1'b1, 8'h5a);
    rd(2'h2, 1'b0, 8'hf7);
    @(posedge sys_clk);
    extLow <= 24'h000080;
    tick(3);
    chk({strongPull[7], weakPull[7]}, 2'h1);
    @(posedge sys_clk);
    extLow <= 24'h0;
    tick(3);
    chk({strongPull[7], weakPull[7]}, 2'h3);
  endtask
  task t_freeze;
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wrReq <= '{1'b1, 2'h0, 1'b0, 3'h0, 8'h00};
    tick(2);
    @(posedge sys_clk);
    wrReq.wrEn <= 1'b0;
    clkEn <= 1'b1;
    tick(3);
    chk(lowDrive[7:0], 8'h00);
    rd(2'h0, 1'b1, 8'hff);
  endtask
  task t_counter;
    @(posedge sys_clk);
    pinFunc[14:12] <= QBP_FN_CNT_OUT;
    pinFunc[20:18] <= QBP_FN_CNT_IN;
    altOut[4] <= 1'b1;
    tick(3);
    chk({lowDrive[4], highDrive[4], lowDrive[6], highDrive[6], strongPull[6], weakPull[6]}, 6'h13);
    @(posedge sys_clk);
    altOut[4] <= 1'b0;
    tick(3);
    chk({lowDrive[4], highDrive[4], strongPull[4], weakPull[4]}, 4'h8);
  endtask
  initial begin
    t_reset();
    t_low_high();
    t_bit_ext();
    t_modes();
    t_wide();
    t_freeze();
    t_counter();
    end_sim();
  end
  initial begin
    #100us;
    n_fail++;
    end_sim();
  end
endmodule
